/* File: include/eru_pkg.sv */
// Constants, encodings and register map of the external request unit.
//
// Contract
// RULE_01: Enabled channel with detected condition raises request.
// RULE_02: Route bit one selects transfer, zero CPU.
// RULE_03: Peripheral withdraws pin within three cycles.
// RULE_04: Pin still present after three cycles re-pends.
// RULE_05: Cause-clear signal clears cause, re-arms detection.
// RULE_06: Only high level may wake from clock-stop.
// RULE_07: Software disables, selects, clears, then enables.
// RULE_08: Cause and enable adjacent for one 16-bit write.
// RULE_09: Edge pulses last at least three cycles.
// RULE_10: Held level cause keeps request until cleared.
// RULE_11: Disabled channel captures cause, forwards nothing; its status bit still sets and reaches irq when unmasked.
// RULE_12: Write zero clears cause; RMW reads ones.
// RULE_13: Select codes: low, high, rising, falling.
// RULE_14: Eight channels; enables and selects reset zero.
// RULE_15: Two-stage synchroniser before any detection.
package eru_pkg;

    // Channel count and field widths.
    localparam int ERU_CH   = 8;
    localparam int ERU_SELW = 2 * ERU_CH;
    localparam int ERU_AW   = 12;
    localparam int ERU_DW   = 32;

    // Register indices; the byte address is four times the index.
    localparam logic [ERU_AW-1:0] IDX_CTL    = 12'h030;
    localparam logic [ERU_AW-1:0] IDX_CAUSE  = 12'h031;
    localparam logic [ERU_AW-1:0] IDX_SELLO  = 12'h032;
    localparam logic [ERU_AW-1:0] IDX_SELHI  = 12'h033;
    localparam logic [ERU_AW-1:0] IDX_STAT   = 12'h040;
    localparam logic [ERU_AW-1:0] IDX_MASK   = 12'h041;
    localparam logic [ERU_AW-1:0] IDX_ROUTE  = 12'h042;
    localparam logic [ERU_AW-1:0] IDX_STATE  = 12'h043;

    // Field positions inside the combined enable and cause word.
    localparam int EN_LSB    = 0;
    localparam int CAUSE_LSB = 8;
    localparam int HIBYTE    = 8;

    // Detection select codes.
    localparam logic [1:0] SEL_LOW  = 2'h0;
    localparam logic [1:0] SEL_HIGH = 2'h1;
    localparam logic [1:0] SEL_RISE = 2'h2;
    localparam logic [1:0] SEL_FALL = 2'h3;

    // Guard after a transfer start, in machine cycles.
    localparam logic [1:0] GUARD_CYCLES = 2'h3;

    // Reset values and fixed read values.
    localparam logic [ERU_CH-1:0]   RST_BYTE = 8'h00;
    localparam logic [ERU_SELW-1:0] RST_SEL  = 16'h0000;
    localparam logic [ERU_DW-1:0]   RD_ZERO  = 32'h0000_0000;
    localparam logic [ERU_CH-1:0]   RMW_ONES = 8'hFF;

    // Bus slave states, one-hot.
    typedef enum logic [1:0] {
        ERU_IDLE = 2'b01,
        ERU_RESP = 2'b10
    } eru_bus_t;

endpackage : eru_pkg

/* File: hdl/eru_sync.sv */
// Two-stage synchroniser for the external request pins.
`timescale 1ns/1ps

module eru_sync
    import eru_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic [ERU_CH-1:0] pinAsync,
    output logic      [ERU_CH-1:0] pinSync
);

    logic [ERU_CH-1:0] stage1;

    // The first stage feeds only the second stage.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            stage1  <= RST_BYTE;
            pinSync <= RST_BYTE;
        end
        else
        begin
            stage1  <= pinAsync;  // [RULE_15]
            pinSync <= stage1;    // [RULE_15]
        end
    end

endmodule : eru_sync

/* File: hdl/eru_detect.sv */
// Per-channel level and edge detector for the request pins.
`timescale 1ns/1ps

module eru_detect
    import eru_pkg::*;
(
    input  wire logic                ref_clk,
    input  wire logic                rst_b,
    input  wire logic [ERU_CH-1:0]   pinSync,
    input  wire logic [ERU_SELW-1:0] detSel,
    output logic      [ERU_CH-1:0]   hit
);

    logic [ERU_CH-1:0] pinPrev;

    // Previous sampled level, used for edge detection.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            pinPrev <= RST_BYTE;
        else
            pinPrev <= pinSync;
    end

    // Each channel picks its condition from its two select bits.
    genvar i;
    generate
        for (i = 0; i < ERU_CH; i++)
        begin : g_det
            wire logic [1:0] sel = detSel[2*i +: 2];
            assign hit[i] =
                (sel == SEL_LOW)  ? ~pinSync[i] :              // [RULE_13]
                (sel == SEL_HIGH) ?  pinSync[i] :              // [RULE_13]
                (sel == SEL_RISE) ? (pinSync[i] & ~pinPrev[i]) // [RULE_13]
                                  : (~pinSync[i] & pinPrev[i]);
        end
    endgenerate

endmodule : eru_detect

/* File: hdl/eru_top.sv */
// External request unit: eight pin channels behind an APB slave.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps

module eru_top
    import eru_pkg::*;
(
    input  wire logic              ref_clk,
    input  wire logic              rst_b,
    input  wire logic              psel,
    input  wire logic              penable,
    input  wire logic              pwrite,
    input  wire logic [ERU_AW-1:0] paddr,
    input  wire logic [ERU_DW-1:0] pwdata,
    input  wire logic [3:0]        pstrb,
    output logic      [ERU_DW-1:0] prdata,
    output logic                   pready,
    output logic                   pslverr,
    input  wire logic [ERU_CH-1:0] extPin,
    input  wire logic [ERU_CH-1:0] xferStart,
    input  wire logic [ERU_CH-1:0] causeClear,
    input  wire logic              rmwRead,
    output logic      [ERU_CH-1:0] cpuReq,
    output logic      [ERU_CH-1:0] xferReq,
    output logic                   wakeReq,
    output logic                   irq
);

    // Register map, one aligned 32-bit word per register. The byte
    // address is four times the index kept in the package.
    // Control word: bits 7..0 enable the channels, bits 15..8 are
    // the cause flags. The two bytes sit side by side so that one
    // halfword write can clear causes and enable channels at once.
    // Cause word: bits 7..0 hold the cause flags alone.
    // Select low word: bits 15..0 hold two select bits per channel.
    // Select high word: bits 7..0 hold the selects of channels
    // four to seven, a second view of the same flops.
    // Status word: bits 7..0 record new causes, write one to clear.
    // Mask word: bits 7..0 let status bits reach the irq line.
    // Route word: a one sends the channel to the transfer path.
    // State word: bits 7..0 synchronised pins, 15..8 guard active.
    // Unmapped addresses answer with pslverr and read as zero.
    //
    // Cause flags leave reset cleared rather than unknown, so no
    // request ever carries an unknown value. With the reset select
    // of low level and idle-low pins every cause sets soon after
    // reset; software must program the selects and clear the
    // causes before it enables a channel.

    // Address decode used for every register.
    function automatic logic hitReg(
        input logic [ERU_AW-1:0] addr,
        input logic [ERU_AW-1:0] idx
    );
        hitReg = (addr == {idx[ERU_AW-3:0], 2'b00});
    endfunction : hitReg

    // Software-visible storage, guard counters and bus state.
    logic [ERU_CH-1:0]   reqEnable;
    logic [ERU_CH-1:0]   reqCause;
    logic [ERU_SELW-1:0] detSel;
    logic [ERU_CH-1:0]   evtStatus;
    logic [ERU_CH-1:0]   evtMask;
    logic [ERU_CH-1:0]   xferRoute;
    logic [1:0]          guardCnt [ERU_CH];
    eru_bus_t            busState;

    // Internal nets.
    logic [ERU_CH-1:0]   pinSync;
    logic [ERU_CH-1:0]   detHit;
    logic [ERU_CH-1:0]   guardOn;
    logic [ERU_CH-1:0]   setCause;
    logic [ERU_CH-1:0]   swClear;
    logic [ERU_CH-1:0]   next_cause;
    logic [ERU_CH-1:0]   next_status;
    logic [ERU_CH-1:0]   reqLive;
    logic [ERU_CH-1:0]   wakeCand;
    logic [ERU_DW-1:0]   readMux;
    logic                 mapped;
    eru_bus_t            next_busState;

    // Pin to request latency: two synchroniser edges, one edge to
    // set the cause and one more to register the request. Edge
    // modes need only the previous-sample flop beside the second
    // stage, so they add no further delay.
    // Everything downstream reads only the second stage, so a
    // metastable first stage can never reach a cause flag.

    // Pins are resynchronised before any detector sees them.
    eru_sync u_sync (
        .ref_clk  (ref_clk),
        .rst_b    (rst_b),
        .pinAsync (extPin),
        .pinSync  (pinSync)
    );

    // The previous-sample flop resets low, matching idle-low pins,
    // so no false rising edge follows reset.
    // Level and edge detection per channel.
    eru_detect u_detect (
        .ref_clk (ref_clk),
        .rst_b   (rst_b),
        .pinSync (pinSync),
        .detSel  (detSel),
        .hit     (detHit)
    );

    // The decode compares the whole byte address, so an address
    // that is not word aligned matches nothing and is unmapped.
    // Bus phase decode. A write or read completes at the edge
    // where pready is high together with psel and penable.
    wire logic accessPh = psel & penable;
    wire logic commit   = accessPh & pready;
    wire logic wrCommit = commit & pwrite;

    wire logic selCtl   = hitReg(paddr, IDX_CTL);
    wire logic selCause = hitReg(paddr, IDX_CAUSE);
    wire logic selSelLo = hitReg(paddr, IDX_SELLO);
    wire logic selSelHi = hitReg(paddr, IDX_SELHI);
    wire logic selStat  = hitReg(paddr, IDX_STAT);
    wire logic selMask  = hitReg(paddr, IDX_MASK);
    wire logic selRoute = hitReg(paddr, IDX_ROUTE);
    wire logic selState = hitReg(paddr, IDX_STATE);

    assign mapped = selCtl | selCause | selSelLo | selSelHi |
                    selStat | selMask | selRoute | selState;

    // Byte-lane write strobes per register.
    wire logic wrEnable  = wrCommit & selCtl & pstrb[0];
    wire logic wrCtlCaus = wrCommit & selCtl & pstrb[1];
    wire logic wrCauseB  = wrCommit & selCause & pstrb[0];
    wire logic wrSelLo0  = wrCommit & selSelLo & pstrb[0];
    wire logic wrSelLo1  = wrCommit & selSelLo & pstrb[1];
    wire logic wrSelHi   = wrCommit & selSelHi & pstrb[0];
    wire logic wrStat    = wrCommit & selStat & pstrb[0];
    wire logic wrMask    = wrCommit & selMask & pstrb[0];
    wire logic wrRoute   = wrCommit & selRoute & pstrb[0];

    // Writing zero clears a cause, writing one leaves it. One
    // 16-bit access to the combined word can clear causes in the
    // upper byte while setting enables in the lower byte.
    assign swClear =
        ({ERU_CH{wrCtlCaus}} & ~pwdata[CAUSE_LSB +: ERU_CH]) |  // [RULE_08]
        ({ERU_CH{wrCauseB}}  & ~pwdata[EN_LSB +: ERU_CH]);      // [RULE_12]

    // Per-channel cause, guard and request logic.
    genvar i;
    generate
        for (i = 0; i < ERU_CH; i++)
        begin : g_ch
            // A guard window follows each transfer start; the pin
            // may still be high while the peripheral withdraws it.
            // A line whose synchronised level drops within three edges never re-pends; a
            // line kept up is seen as a fresh transfer request. A
            // start strobe inside a running window restarts it.
            always_ff @(posedge ref_clk or negedge rst_b)
            begin
                if (!rst_b)
                    guardCnt[i] <= 2'h0;
                else if (xferStart[i])
                    guardCnt[i] <= GUARD_CYCLES;               // [RULE_04]
                else if (guardOn[i])
                    guardCnt[i] <= guardCnt[i] - 2'h1;
            end

            assign guardOn[i] = (guardCnt[i] != 2'h0);

            // Detection is blind during the guard; a pin still
            // present afterwards pends a fresh request.
            assign setCause[i] = detHit[i] & ~guardOn[i];     // [RULE_04]

            // Hardware set wins over both clear sources.
            // A cause that arrives during a clear is thus never
            // lost; it simply stays pending.
            assign next_cause[i] = setCause[i] |               // [RULE_10]
                (reqCause[i] & ~(swClear[i] | causeClear[i])); // [RULE_05]

            // A new cause is an event for the status register.
            // A status clear in the same cycle as a new event
            // loses to the event, so no event is dropped.
            assign next_status[i] = (setCause[i] & ~reqCause[i]) |
                (evtStatus[i] & ~(wrStat & pwdata[i]));
        end
    endgenerate

    // Causes are captured regardless of enable; only enabled
    // channels pass a request on.
    assign reqLive = reqCause & reqEnable;                     // [RULE_11]

    // The wake line is a hint to the clock controller only. It is
    // not latched, so it drops three edges after the pin goes low.
    // Only high-level channels are wake candidates. Edge detection
    // needs a running clock and low level is unreliable there.
    generate
        for (i = 0; i < ERU_CH; i++)
        begin : g_wake
            assign wakeCand[i] = reqEnable[i] & pinSync[i] &
                                 (detSel[2*i +: 2] == SEL_HIGH); // [RULE_06]
        end
    endgenerate

    // Cause flags and their event status.
    // A status event fires only on the cycle a cause goes from
    // clear to set, so a held level counts once.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reqCause  <= RST_BYTE;
            evtStatus <= RST_BYTE;
        end
        else
        begin
            reqCause  <= next_cause;   // [RULE_05]
            evtStatus <= next_status;
        end
    end

    // Enables, routing and event mask.
    // These change only on a committed write. A write to one lane
    // of the control word leaves the other lane alone, which is
    // what lets causes and enables share one word.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            reqEnable <= RST_BYTE;     // [RULE_14]
            xferRoute <= RST_BYTE;
            evtMask   <= RST_BYTE;
        end
        else
        begin
            if (wrEnable)
                reqEnable <= pwdata[EN_LSB +: ERU_CH];
            if (wrRoute)
                xferRoute <= pwdata[EN_LSB +: ERU_CH];
            if (wrMask)
                evtMask <= pwdata[EN_LSB +: ERU_CH];
        end
    end

    // Detection select, reachable as one halfword or by upper byte.
    // Changing a select on an enabled channel can fake an edge or
    // a level hit; disabling first, then selecting, then clearing
    // the cause keeps a spurious request from escaping.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
            detSel <= RST_SEL;         // [RULE_14]
        else
        begin
            if (wrSelLo0)
                detSel[0 +: HIBYTE] <= pwdata[0 +: HIBYTE];
            if (wrSelLo1 | wrSelHi)
                detSel[HIBYTE +: HIBYTE] <= wrSelHi
                    ? pwdata[0 +: HIBYTE]
                    : pwdata[HIBYTE +: HIBYTE];
        end
    end

    // Requests toward the interrupt controller, split by route.
    // Registering them gives the controller clean levels at the
    // cost of one more edge of latency on every request.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            cpuReq  <= RST_BYTE;
            xferReq <= RST_BYTE;
            wakeReq <= 1'b0;
            irq     <= 1'b0;
        end
        else
        begin
            cpuReq  <= reqLive & ~xferRoute;  // [RULE_01] [RULE_02]
            xferReq <= reqLive & xferRoute;   // [RULE_01] [RULE_02]
            wakeReq <= |wakeCand;              // [RULE_06]
            irq     <= |(evtStatus & evtMask);
        end
    end

    // The select-high view is the upper byte of the select word,
    // so the two views can never disagree.
    // Read data selection. Cause bytes read as all ones during a
    // read-modify-write so the write back clears nothing.
    wire logic [ERU_CH-1:0] causeView =
        rmwRead ? RMW_ONES : reqCause;                          // [RULE_12]

    assign readMux =
        selCtl   ? {16'h0000, causeView, reqEnable} :          // [RULE_08]
        selCause ? {24'h00_0000, causeView} :
        selSelLo ? {16'h0000, detSel} :
        selSelHi ? {24'h00_0000, detSel[HIBYTE +: HIBYTE]} :
        selStat  ? {24'h00_0000, evtStatus} :
        selMask  ? {24'h00_0000, evtMask} :
        selRoute ? {24'h00_0000, xferRoute} :
        selState ? {16'h0000, guardOn, pinSync} :
                   RD_ZERO;

    // Walk of one transfer: after the setup edge, the first access
    // edge moves the state to answer and loads pready, prdata and
    // pslverr; the second access edge sees pready high and commits
    // the write. The master then drops psel and penable. A setup
    // right after is fine, as the state is idle again by then.
    // Every access pays one wait state; in exchange the outputs
    // are registered and no combinational path runs from paddr
    // to prdata.
    // Slave answers one cycle into the access phase. The added
    // wait state keeps pready and prdata straight from flops.
    always_comb
    begin
        next_busState = busState;
        case (busState)
            ERU_IDLE:
                if (accessPh)
                    next_busState = ERU_RESP;
            ERU_RESP:
                next_busState = ERU_IDLE;
            default:
                next_busState = ERU_IDLE;
        endcase
    end

    // Bus state and registered answer.
    always_ff @(posedge ref_clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            busState <= ERU_IDLE;
            pready   <= 1'b0;
            pslverr  <= 1'b0;
            prdata   <= RD_ZERO;
        end
        else
        begin
            busState <= next_busState;
            pready   <= (next_busState == ERU_RESP);
            pslverr  <= (next_busState == ERU_RESP) & ~mapped;
            prdata   <= (next_busState == ERU_RESP) & ~pwrite
                        ? readMux : RD_ZERO;
        end
    end

endmodule : eru_top

/* File: sim/eru_chk.sv */
// Port-level assertions for the external request unit.
`timescale 1ns/1ps

module eru_chk
    import eru_pkg::*;
(
    input wire logic              ref_clk,
    input wire logic              rst_b,
    input wire logic              psel,
    input wire logic              penable,
    input wire logic [ERU_DW-1:0] prdata,
    input wire logic              pready,
    input wire logic              pslverr,
    input wire logic [ERU_CH-1:0] extPin,
    input wire logic [ERU_CH-1:0] causeClear,
    input wire logic [ERU_CH-1:0] cpuReq,
    input wire logic [ERU_CH-1:0] xferReq,
    input wire logic              wakeReq
);
    // Everything here lives on the machine clock and its reset.
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!rst_b);

    // The bus answers after exactly one wait state, with one-cycle strobes.
    ready_wait_a: assert property (
        $rose(penable) && psel |=> pready)
        else $error("ready missing one cycle into access");
    ready_pulse_a: assert property (
        pready |=> !pready)
        else $error("ready held past one cycle");
    ready_req_a: assert property (
        pready |-> psel && penable)
        else $error("ready without an access");
    err_ready_a: assert property (
        pslverr |-> pready)
        else $error("error strobe without ready");
    rdata_idle_a: assert property (
        !pready |-> prdata == '0)
        else $error("read data outside the answer cycle");

    // A request goes to one destination only.
    route_excl_a: assert property (
        (cpuReq & xferReq) == '0)
        else $error("request on both paths");

    // Without a bus access or a clear strobe, no request may drop.
    req_hold_a: assert property (
        !psel && !$past(psel) && !$past(psel, 2) &&
        $past(causeClear) == '0 && $past(causeClear, 2) == '0
        |-> ($past(cpuReq | xferReq) & ~(cpuReq | xferReq)) == '0)
        else $error("request dropped without a clear");

    // Wake needs a pin that was high through the synchroniser.
    wake_pin_a: assert property (
        wakeReq |-> (|$past(extPin, 2)) || (|$past(extPin, 3)))
        else $error("wake without a high pin");
endmodule : eru_chk

bind eru_top eru_chk chk (.ref_clk, .rst_b, .psel, .penable, .prdata,
    .pready, .pslverr, .extPin, .causeClear, .cpuReq, .xferReq, .wakeReq);

/* File: sim/eru_periph.sv */
// Behavioural external peripheral driving the request pins.
`timescale 1ns/1ps

module eru_periph
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] xferStart,
    output logic      [7:0] extPin
);
    logic [7:0] autoDrop;
    logic [7:0] dropDue;

    // Pins start idle low; auto-drop is off until the bench asks.
    initial
    begin
        {extPin, autoDrop, dropDue} = '0;
    end

    // Auto-clearing lines fall two cycles after the transfer starts.
    always @(posedge ref_clk)
    begin
        dropDue <= xferStart & autoDrop;
        if (|dropDue)
            extPin <= extPin & ~dropDue;
    end

    task automatic drive(input int ch, input logic v);
        extPin[ch] <= v;
    endtask : drive

    // Pulses last three cycles, the least the edge detector needs.
    task automatic pulse(input int ch, input logic v);
        extPin[ch] <= v;
        repeat (3) @(posedge ref_clk);
        extPin[ch] <= ~v;
    endtask : pulse
endmodule : eru_periph

/* File: sim/eru_tb.sv */
// Self-checking bench for the external request unit.
`timescale 1ns/1ps

module tb
    import eru_pkg::*;
;
    logic              ref_clk, rst_b, psel, penable, pwrite, rmwRead;
    logic              pready, pslverr, wakeReq, irq, perr, act;
    logic [ERU_AW-1:0] paddr;
    logic [ERU_DW-1:0] pwdata, prdata, rdv;
    logic [3:0]        pstrb;
    logic [ERU_CH-1:0] extPin, xferStart, causeClear, cpuReq, xferReq, en;
    int                error_cnt, comparisons;

    eru_top uut (.ref_clk, .rst_b, .psel, .penable, .pwrite, .paddr,
        .pwdata, .pstrb, .prdata, .pready, .pslverr, .extPin, .xferStart,
        .causeClear, .rmwRead, .cpuReq, .xferReq, .wakeReq, .irq);
    eru_periph per (.ref_clk, .xferStart, .extPin);

    // Free-running 4 ns machine clock.
    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    task automatic final_report;
        $display("checks %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : final_report

    task automatic chk(input string nm, input logic [31:0] exp, got);
        comparisons++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk

    function automatic logic [11:0] ad(input logic [11:0] i);
        return i << 2;
    endfunction : ad

    // One bus transfer; an idle edge follows so calls never collide.
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d, input logic [3:0] s);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= w;
        paddr  <= a;
        pwdata <= d;
        pstrb  <= s;
        @(posedge ref_clk);
        penable <= 1'b1;
        do
        begin
            @(posedge ref_clk);
            n++;
        end
        while (pready !== 1'b1 && n < 20);
        rdv = prdata;
        perr = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1)
        begin
            error_cnt++;
            final_report();
        end
        @(posedge ref_clk);
    endtask : apb

    task automatic waitreq(input int i, input logic x, input logic v);
        int n;
        n = 0;
        while ((x ? xferReq[i] : cpuReq[i]) !== v && n < 30)
        begin
            @(posedge ref_clk);
            n++;
        end
        chk("request", v, x ? xferReq[i] : cpuReq[i]);
        if (n == 30)
            final_report();
    endtask : waitreq

    task automatic strobe(input logic clr, input int i);
        if (clr)
            causeClear[i] <= 1'b1;
        else
            xferStart[i] <= 1'b1;
        @(posedge ref_clk);
        if (clr)
            causeClear[i] <= 1'b0;
        else
            xferStart[i] <= 1'b0;
    endtask : strobe

    // Disable, select, then clear the cause and enable in one word.
    task automatic cfg(input int i, input logic [1:0] code);
        en[i] = 1'b0;
        apb(1, ad(IDX_CTL), {24'h00_0000, en}, 4'h1);
        apb(1, ad(IDX_SELLO), 32'h0000_5555 & ~(32'h3 << 2*i) | code << 2*i,
            4'hF);
        en[i] = 1'b1;
        apb(1, ad(IDX_CTL), {16'h0000, ~(8'h01 << i), en}, 4'h3);
    endtask : cfg

    // Main sequence.
    initial
    begin
        {rst_b, psel, penable, pwrite, rmwRead, paddr, pwdata, pstrb} = '0;
        {xferStart, causeClear, en} = '0;
        repeat (10) @(posedge ref_clk);
        rst_b <= 1'b1;
        @(posedge ref_clk);
        chk("outs", '0, {cpuReq, xferReq, wakeReq, irq, pready});
        apb(0, ad(IDX_CTL), '0, '0);
        // Low-level selects on idle-low pins set every cause at once.
        chk("enables", 32'h0000_FF00, rdv);
        apb(0, ad(IDX_SELLO), '0, '0);
        chk("selects", '0, rdv);
        apb(0, 12'h3FC, '0, '0);
        chk("unmapped", 1, perr);
        apb(1, ad(IDX_SELLO), 32'h0000_5555, 4'hF);
        apb(1, ad(IDX_CTL), '0, 4'h3);
        apb(1, ad(IDX_ROUTE), 32'h0000_0008, 4'hF);
        $display("test reset done");
        cfg(0, SEL_HIGH);
        per.drive(0, 1'b1);
        waitreq(0, 0, 1);
        chk("wake", 1, wakeReq);
        per.drive(0, 1'b0);
        repeat (8) @(posedge ref_clk);
        chk("held", 1, cpuReq[0]);
        chk("wake", 0, wakeReq);
        apb(0, ad(IDX_CAUSE), '0, '0);
        chk("cause", 32'h0000_0001, rdv);
        rmwRead <= 1'b1;
        apb(0, ad(IDX_CAUSE), '0, '0);
        chk("rmw", 8'hFF, rdv[7:0]);
        rmwRead <= 1'b0;
        apb(1, ad(IDX_CAUSE), 32'h0000_00FF, 4'hF);
        apb(0, ad(IDX_CAUSE), '0, '0);
        chk("kept", 32'h0000_0001, rdv);
        apb(1, ad(IDX_CAUSE), 32'h0000_00FE, 4'hF);
        waitreq(0, 0, 0);
        $display("test level done");
        per.drive(1, 1'b1);
        repeat (8) @(posedge ref_clk);
        chk("off", 0, cpuReq[1]);
        apb(0, ad(IDX_CAUSE), '0, '0);
        chk("cause", 32'h0000_0002, rdv);
        per.drive(1, 1'b0);
        for (int k = 0; k < 4; k++)
        begin
            act = (k == 1 || k == 2);
            per.drive(2, !act);
            repeat (6) @(posedge ref_clk);
            cfg(2, k[1:0]);
            repeat (8) @(posedge ref_clk);
            chk("idle", 0, cpuReq[2]);
            chk("no wake", 0, wakeReq);
            per.pulse(2, act);
            waitreq(2, 0, 1);
            apb(1, ad(IDX_CAUSE), 32'h0000_00FB, 4'hF);
            waitreq(2, 0, 0);
        end
        en[2] = 1'b0;
        apb(1, ad(IDX_CTL), {24'h00_0000, en}, 4'h1);
        per.drive(2, 1'b0);
        $display("test modes done");
        per.autoDrop <= 8'h08;
        cfg(3, SEL_HIGH);
        per.drive(3, 1'b1);
        waitreq(3, 1, 1);
        chk("cpu path", 0, cpuReq[3]);
        strobe(0, 3);
        repeat (3) @(posedge ref_clk);
        strobe(1, 3);
        waitreq(3, 1, 0);
        per.autoDrop <= 8'h00;
        per.drive(3, 1'b1);
        waitreq(3, 1, 1);
        strobe(0, 3);
        strobe(1, 3);
        waitreq(3, 1, 0);
        waitreq(3, 1, 1);
        per.drive(3, 1'b0);
        repeat (6) @(posedge ref_clk);
        strobe(1, 3);
        waitreq(3, 1, 0);
        $display("test transfer done");
        apb(1, ad(IDX_MASK), 32'h0000_000F, 4'hF);
        repeat (3) @(posedge ref_clk);
        chk("irq on", 1, irq);
        apb(1, ad(IDX_MASK), '0, 4'hF);
        repeat (3) @(posedge ref_clk);
        chk("irq masked", 0, irq);
        apb(1, ad(IDX_MASK), 32'h0000_000F, 4'hF);
        apb(1, ad(IDX_STAT), 32'h0000_00FF, 4'hF);
        repeat (3) @(posedge ref_clk);
        chk("irq cleared", 0, irq);
        $display("test interrupt done");
        final_report();
    end
endmodule : tb
